// file: design/vsg_pkg.sv
`default_nettype none

package vsg_pkg;

    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_SENSE_GAIN = 8'h2A;
    localparam logic [7:0] CMD_FLOOR_LIMIT = 8'h2B;

    // ----------------------------------------
    // sense-gain field layout
    // ----------------------------------------
    localparam int GAIN_EXP_HI = 15;
    localparam int GAIN_EXP_LO = 11;
    localparam int GAIN_MANT_HI = 3;
    localparam logic [4:0] GAIN_EXPONENT = 5'h1D;
    localparam logic [3:0] GAIN_MANT_RESET = 4'h8;

    // restore mantissas for gains 0.125, 0.25, 0.5, 1.0
    localparam logic [3:0] RESTORE_G0 = 4'h1;
    localparam logic [3:0] RESTORE_G1 = 4'h2;
    localparam logic [3:0] RESTORE_G2 = 4'h4;
    localparam logic [3:0] RESTORE_G3 = 4'h8;

    // ----------------------------------------
    // floor-limit field layout
    // ----------------------------------------
    localparam int FLOOR_HI = 11;
    localparam logic [11:0] FLOOR_RESET = 12'h000;
    localparam logic [11:0] FLOOR_VALID_MIN_DEF = 12'h000;
    localparam logic [11:0] FLOOR_VALID_MAX_DEF = 12'hFFF;

    // gain setting code: 0 = 0.125, 1 = 0.25, 2 = 0.5, 3 = 1.0
    typedef logic [1:0] vsg_gain_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_NVM,
        SRC_PIN
    } vsg_src_e;

endpackage : vsg_pkg

`default_nettype wire

// file: design/vsg_gain_map.sv
`timescale 1ns/1ps
`default_nettype none

// maps a nonzero mantissa to the divider gain code of its highest set bit, rounding down; zero gives code 0
module vsg_gain_map (
    input wire logic [3:0] mant_in,
    output logic [1:0] gain_out,
    output logic [3:0] restore_out
);

    function automatic logic [1:0] gain_of(input logic [3:0] m);
        if (m[3])
            gain_of = 2'h3;
        else if (m[2])
            gain_of = 2'h2;
        else if (m[1])
            gain_of = 2'h1;
        else
            gain_of = 2'h0;
    endfunction : gain_of

    wire logic [1:0] code;

    assign code = gain_of(mant_in);
    assign gain_out = code;
    assign restore_out = (code == 2'h3) ? vsg_pkg::RESTORE_G3 :
                         (code == 2'h2) ? vsg_pkg::RESTORE_G2 :
                         (code == 2'h1) ? vsg_pkg::RESTORE_G1 :
                         vsg_pkg::RESTORE_G0;

endmodule : vsg_gain_map

`default_nettype wire

// file: design/vsg_floor_check.sv
`timescale 1ns/1ps
`default_nettype none

// compares a target against the floor and checks a floor write for range
module vsg_floor_check (
    input wire logic [11:0] target_in,
    input wire logic [11:0] floor_in,
    input wire logic [11:0] wdata_in,
    input wire logic [11:0] vmin_in,
    input wire logic [11:0] vmax_in,
    output logic below_out,
    output logic wr_bad_out
);

    assign below_out = target_in < floor_in;
    assign wr_bad_out = (wdata_in < vmin_in) || (wdata_in > vmax_in);

endmodule : vsg_floor_check

`default_nettype wire

// file: design/vsg_regs.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// ----------------------------------------
module vsg_regs (
    input wire logic clk_in,
    input wire logic srst_in,
    // word command port
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] cmd_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic unsup_out,
    output logic invalid_out,
    // straps and restore
    input wire logic feedback_mode_strap_in,
    input wire logic strap_override_bit_in,
    input wire logic [3:0] pin_gain_mant_in,
    input wire logic [3:0] nvm_gain_mant_in,
    input wire logic [11:0] nvm_floor_in,
    input wire logic restore_in,
    input wire logic [3:0] loop_gain_mant_in,
    // regulation side
    input wire logic converting_in,
    input wire logic [11:0] target_in,
    input wire logic [11:0] vmin_in,
    input wire logic [11:0] vmax_in,
    output logic [1:0] sense_gain_out,
    output logic [11:0] applied_target_out,
    output logic clamp_out,
    output logic status_other_out,
    output logic status_word_vout_out,
    output logic status_vout_warn_out,
    output logic alert_out,
    input wire logic status_clear_in
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0] gain_mant;
    logic [11:0] floor_val;
    logic restore_done;

    wire logic external_fb;
    wire logic [3:0] shown_mant;
    wire logic [1:0] gain_code;
    wire logic [3:0] restore_mant;
    wire logic [3:0] boot_src_mant;
    wire logic wr_gain;
    wire logic wr_floor;
    wire logic gain_refused;
    wire logic below;
    wire logic wr_bad;
    wire logic warn;
    wire logic [15:0] next_rdata;

    assign external_fb = feedback_mode_strap_in;
    // internal divider shows the loop gain instead of the stored value
    assign shown_mant = external_fb ? gain_mant : loop_gain_mant_in;
    assign wr_gain = wr_in && (cmd_in == vsg_pkg::CMD_SENSE_GAIN);
    assign wr_floor = wr_in && (cmd_in == vsg_pkg::CMD_FLOOR_LIMIT);
    assign gain_refused = wr_gain && !external_fb;

    vsg_gain_map u_map (
        .mant_in(shown_mant),
        .gain_out(gain_code),
        .restore_out()
    );

    vsg_gain_map u_restore_map (
        .mant_in(nvm_gain_mant_in),
        .gain_out(),
        .restore_out(restore_mant)
    );

    vsg_floor_check u_chk (
        .target_in(target_in),
        .floor_in(floor_val),
        .wdata_in(wdata_in[vsg_pkg::FLOOR_HI:0]),
        .vmin_in(vmin_in),
        .vmax_in(vmax_in),
        .below_out(below),
        .wr_bad_out(wr_bad)
    );

    // pin resistance wins unless the override strap says nvm
    assign boot_src_mant = strap_override_bit_in ? restore_mant : pin_gain_mant_in;

    // floor above target or target dropped below floor, both while converting
    assign warn = converting_in && below;

    // exponent fixed, unused bits zero: only mantissa is stored
    assign next_rdata =
        (cmd_in == vsg_pkg::CMD_SENSE_GAIN) ?
            {vsg_pkg::GAIN_EXPONENT, 7'h00, shown_mant} :
        (cmd_in == vsg_pkg::CMD_FLOOR_LIMIT) ? {4'h0, floor_val} :
        16'h0000;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            gain_mant <= vsg_pkg::GAIN_MANT_RESET;
            floor_val <= vsg_pkg::FLOOR_RESET;
            restore_done <= 1'b0;
        end
        else if (restore_in || !restore_done)
        begin
            gain_mant <= boot_src_mant;
            floor_val <= nvm_floor_in;
            restore_done <= 1'b1;
        end
        else
        begin
            if (wr_gain && external_fb)
                gain_mant <= wdata_in[vsg_pkg::GAIN_MANT_HI:0];
            if (wr_floor && !wr_bad)
                floor_val <= wdata_in[vsg_pkg::FLOOR_HI:0];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            rdata_out <= 16'h0000;
            rvalid_out <= 1'b0;
            sense_gain_out <= 2'h3;
            applied_target_out <= 12'h000;
            clamp_out <= 1'b0;
        end
        else
        begin
            rvalid_out <= rd_in;
            if (rd_in)
                rdata_out <= next_rdata;
            sense_gain_out <= gain_code;
            applied_target_out <= warn ? floor_val : target_in;
            clamp_out <= warn;
        end
    end

    // sticky status; a new event in the clear cycle wins
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            status_other_out <= 1'b0;
            status_word_vout_out <= 1'b0;
            status_vout_warn_out <= 1'b0;
            unsup_out <= 1'b0;
            invalid_out <= 1'b0;
            alert_out <= 1'b0;
        end
        else
        begin
            status_other_out <= warn | (status_other_out & ~status_clear_in);
            status_word_vout_out <= warn | (status_word_vout_out & ~status_clear_in);
            status_vout_warn_out <= warn | (status_vout_warn_out & ~status_clear_in);
            unsup_out <= gain_refused | (unsup_out & ~status_clear_in);
            invalid_out <= (wr_floor & wr_bad) | (invalid_out & ~status_clear_in);
            alert_out <= warn | gain_refused | (wr_floor & wr_bad) |
                         (alert_out & ~status_clear_in);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_refused_write;
        wr_gain && !external_fb && restore_done && !restore_in;
    endsequence

    a_gain_refused: assert property (@(posedge clk_in) disable iff (srst_in)
        s_refused_write |=> ($stable(gain_mant) && unsup_out && alert_out))
        else $error("refused gain write changed state");

    a_gain_write: assert property (@(posedge clk_in) disable iff (srst_in)
        (wr_gain && external_fb && restore_done && !restore_in)
        |=> gain_mant == $past(wdata_in[3:0]))
        else $error("gain write not applied");

    a_read_layout: assert property (@(posedge clk_in) disable iff (srst_in)
        (rd_in && cmd_in == vsg_pkg::CMD_SENSE_GAIN)
        |=> rvalid_out && rdata_out[15:4] == {5'h1D, 7'h00})
        else $error("gain read fixed bits wrong");

    a_floor_upper: assert property (@(posedge clk_in) disable iff (srst_in)
        (rd_in && cmd_in == vsg_pkg::CMD_FLOOR_LIMIT) |=> rdata_out[15:12] == 4'h0)
        else $error("floor upper bits not zero");

    a_clamp_value: assert property (@(posedge clk_in) disable iff (srst_in)
        (converting_in && target_in < floor_val)
        |=> clamp_out && applied_target_out == $past(floor_val))
        else $error("clamp not applied");

    a_status_set: assert property (@(posedge clk_in) disable iff (srst_in)
        warn |=> status_other_out && status_word_vout_out && status_vout_warn_out
        ##0 alert_out)
        else $error("warning status missing");

    a_bad_floor: assert property (@(posedge clk_in) disable iff (srst_in)
        (wr_floor && wr_bad && restore_done && !restore_in)
        |=> $stable(floor_val) && invalid_out)
        else $error("invalid floor write accepted");

    a_gain_mirror: assert property (@(posedge clk_in) disable iff (srst_in)
        (rd_in && cmd_in == vsg_pkg::CMD_SENSE_GAIN && !external_fb)
        |=> rdata_out[3:0] == $past(loop_gain_mant_in))
        else $error("internal mode not mirroring loop gain");

    a_gain_map: assert property (@(posedge clk_in) disable iff (srst_in)
        (shown_mant >= 4'h8) |=> sense_gain_out == 2'h3)
        else $error("gain mapping wrong");

    // the reset-release edge is kept out: outputs there still show reset values
    sequence s_restore_step;
        !srst_in && (restore_in || !restore_done);
    endsequence

    sequence s_live_floor_write;
        !srst_in && wr_floor && !wr_bad && restore_done && !restore_in;
    endsequence

    a_floor_write: assert property (@(posedge clk_in) disable iff (srst_in)
        s_live_floor_write |=> floor_val == $past(wdata_in[11:0]))
        else $error("floor write not applied");

    a_restore_floor: assert property (@(posedge clk_in) disable iff (srst_in)
        s_restore_step |=> floor_val == $past(nvm_floor_in))
        else $error("floor not restored");

    a_restore_pin: assert property (@(posedge clk_in) disable iff (srst_in)
        s_restore_step ##0 !strap_override_bit_in |=> gain_mant == $past(pin_gain_mant_in))
        else $error("gain not taken from pin");

    a_restore_fixed: assert property (@(posedge clk_in) disable iff (srst_in)
        s_restore_step ##0 strap_override_bit_in |=> gain_mant inside
            {vsg_pkg::RESTORE_G0, vsg_pkg::RESTORE_G1, vsg_pkg::RESTORE_G2, vsg_pkg::RESTORE_G3})
        else $error("restored mantissa not a fixed value");

    a_clamp_release: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && converting_in && !below)
        |=> !clamp_out && applied_target_out == $past(target_in))
        else $error("clamp held without cause");

    a_clamp_idle: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && !converting_in) |=> !clamp_out)
        else $error("clamp while not converting");

    a_status_clear: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && status_clear_in && !warn)
        |=> !status_other_out && !status_word_vout_out && !status_vout_warn_out)
        else $error("status not cleared");

    a_alert_cause: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && !alert_out && !warn && !gain_refused && !(wr_floor && wr_bad))
        |=> !alert_out)
        else $error("alert raised without cause");

    a_unsup_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (unsup_out && !status_clear_in) |=> unsup_out)
        else $error("unsupported flag lost");

    a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && !rd_in) |=> !rvalid_out)
        else $error("read valid without read");

    a_gain_low: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && shown_mant < 4'h2) |=> sense_gain_out == 2'h0)
        else $error("low gain mapping wrong");

    a_gain_mid: assert property (@(posedge clk_in) disable iff (srst_in)
        (!srst_in && shown_mant[3:2] == 2'h1) |=> sense_gain_out == 2'h2)
        else $error("half gain mapping wrong");

endmodule : vsg_regs

`default_nettype wire

// file: verif/vsg_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// host side of the word command port
// ----------------------------------------
module vsg_host (
    input wire logic clk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] cmd_out,
    output logic [15:0] wdata_out,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in
);
    // gain choice against the sense voltage limit is left to the user
    initial
    begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        cmd_out = 8'h00;
        wdata_out = 16'h0000;
    end

    // released data flips so a stale word is never mistaken for a live one
    task automatic write_word(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        cmd_out <= c;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        cmd_out <= ~c;
        wdata_out <= ~d;
    endtask : write_word

    task automatic read_word(input logic [7:0] c, output logic [15:0] d, output logic v);
        @(posedge clk_in);
        rd_out <= 1'b1;
        cmd_out <= c;
        @(posedge clk_in);
        rd_out <= 1'b0;
        cmd_out <= ~c;
        #1;
        d = rdata_in;
        v = rvalid_in;
    endtask : read_word
endmodule : vsg_host

`default_nettype wire

// file: verif/vsg_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module vsg_regs_tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic wr, rd, rv, unsup, inval, fbs = 1'b1, ovr = 1'b1, rst_ld = 1'b0, conv = 1'b0;
    logic clr = 1'b0, clamp, s_oth, s_word, s_warn, alert;
    logic [7:0] cmd;
    logic [15:0] wd, rdat, d;
    logic [3:0] pin_m = 4'h2, nvm_m = 4'h5, loop_m = 4'h4;
    logic [11:0] nvm_f = 12'h123, tgt = 12'h400, vmin = 12'h010, vmax = 12'h800, app;
    logic [1:0] gain;
    logic v;
    int n_errors = 0;
    int compares = 0;

    always #4 clk_in = ~clk_in;

    vsg_host i_vsg_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .cmd_out(cmd),
        .wdata_out(wd), .rdata_in(rdat), .rvalid_in(rv));

    vsg_regs i_vsg_regs (.clk_in(clk_in), .srst_in(srst_in), .wr_in(wr), .rd_in(rd),
        .cmd_in(cmd), .wdata_in(wd), .rdata_out(rdat), .rvalid_out(rv), .unsup_out(unsup),
        .invalid_out(inval), .feedback_mode_strap_in(fbs), .strap_override_bit_in(ovr),
        .pin_gain_mant_in(pin_m), .nvm_gain_mant_in(nvm_m), .nvm_floor_in(nvm_f),
        .restore_in(rst_ld), .loop_gain_mant_in(loop_m), .converting_in(conv),
        .target_in(tgt), .vmin_in(vmin), .vmax_in(vmax), .sense_gain_out(gain),
        .applied_target_out(app), .clamp_out(clamp), .status_other_out(s_oth),
        .status_word_vout_out(s_word), .status_vout_warn_out(s_warn), .alert_out(alert),
        .status_clear_in(clr));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic flags(input logic [15:0] e);
        chk("flags", e, {11'h0, clamp, s_oth, s_word, s_warn, alert});
    endtask : flags

    task automatic pulse_clear();
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        settle(1);
    endtask : pulse_clear

    task automatic t_restore();
        i_vsg_host.read_word(8'h2A, d, v);
        chk("gain_word", 16'hE804, d);
        chk("rvalid", 16'h0001, {15'h0, v});
        chk("gain_code", 16'h0002, {14'h0, gain});
        i_vsg_host.read_word(8'h2B, d, v);
        chk("floor_word", 16'h0123, d);
        // override cleared in the same cycle as the restore a power cycle would bring
        @(posedge clk_in);
        ovr <= 1'b0;
        rst_ld <= 1'b1;
        @(posedge clk_in);
        rst_ld <= 1'b0;
        settle(2);
        i_vsg_host.read_word(8'h2A, d, v);
        chk("pin_gain", 16'hE802, d);
        $display("test restore done");
    endtask : t_restore

    task automatic t_gain();
        for (int m = 0; m < 16; m++)
        begin
            i_vsg_host.write_word(8'h2A, 16'hFFF0 | 16'(m));
            i_vsg_host.read_word(8'h2A, d, v);
            chk("gain_rb", 16'hE800 | 16'(m), d);
            chk("gain_code", (m < 2) ? 16'h0 : (m < 4) ? 16'h1 : (m < 8) ? 16'h2 : 16'h3,
                {14'h0, gain});
        end
        $display("test gain done");
    endtask : t_gain

    task automatic t_internal();
        @(posedge clk_in);
        fbs <= 1'b0;
        settle(1);
        i_vsg_host.read_word(8'h2A, d, v);
        chk("mirror", 16'hE804, d);
        i_vsg_host.write_word(8'h2A, 16'h0009);
        i_vsg_host.read_word(8'h2A, d, v);
        chk("refused", 16'hE804, d);
        chk("unsup", 16'h0003, {14'h0, unsup, alert});
        pulse_clear();
        chk("unsup_clr", 16'h0000, {14'h0, unsup, alert});
        @(posedge clk_in);
        fbs <= 1'b1;
        $display("test internal done");
    endtask : t_internal

    task automatic t_floor();
        i_vsg_host.write_word(8'h2B, 16'h0FFF);
        i_vsg_host.read_word(8'h2B, d, v);
        chk("floor_bad", 16'h0123, d);
        chk("invalid", 16'h0003, {14'h0, inval, alert});
        pulse_clear();
        i_vsg_host.write_word(8'h2B, 16'h0300);
        i_vsg_host.read_word(8'h2B, d, v);
        chk("floor_rb", 16'h0300, d);
        i_vsg_host.write_word(8'h2B, 16'h0005);
        i_vsg_host.read_word(8'h2B, d, v);
        chk("floor_low", 16'h0300, d);
        chk("invalid_low", 16'h0003, {14'h0, inval, alert});
        pulse_clear();
        $display("test floor done");
    endtask : t_floor

    task automatic t_clamp();
        @(posedge clk_in);
        conv <= 1'b1;
        settle(2);
        flags(16'h0000);
        chk("applied", 16'h0400, {4'h0, app});
        i_vsg_host.write_word(8'h2B, 16'h0500);
        settle(1);
        flags(16'h001F);
        chk("applied", 16'h0500, {4'h0, app});
        i_vsg_host.write_word(8'h2B, 16'h0100);
        pulse_clear();
        flags(16'h0000);
        @(posedge clk_in);
        tgt <= 12'h080;
        settle(2);
        flags(16'h001F);
        chk("applied", 16'h0100, {4'h0, app});
        $display("test clamp done");
    endtask : t_clamp

    task automatic test_done();
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial
    begin
        #(8 * 5000);
        n_errors++;
        test_done();
    end

    initial
    begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        settle(3);
        t_restore();
        t_gain();
        t_internal();
        t_floor();
        t_clamp();
        test_done();
    end
endmodule : vsg_regs_tb_top

`default_nettype wire
